// file: pkg/hduf_pkg.sv
`default_nettype none
package hduf_pkg;
    // ------------------------------------------------------------------
    // Line framing constants
    // ------------------------------------------------------------------
    localparam logic [7:0]  FLAG_OCTET  = 8'h7E;
    localparam logic [2:0]  STUFF_RUN   = 3'h5;  // Ones before a zero is stuffed
    localparam logic [2:0]  FLAG_RUN    = 3'h6;  // Ones inside a flag
    localparam logic [2:0]  RUN_MAX     = 3'h7;  // Abort run, counter saturates here
    localparam logic [3:0]  BYTE_BITS   = 4'h8;
    localparam logic [3:0]  TX_CNT_RST  = 4'h8;  // Forces a byte decision on first request

    // ------------------------------------------------------------------
    // Frame check sequence
    // ------------------------------------------------------------------
    localparam logic [15:0] CRC_PRESET  = 16'hFFFF;
    localparam logic [15:0] CRC_POLY    = 16'h8408;  // Reflected form, LSB first
    localparam logic [15:0] CRC_GOOD    = 16'hF0B8;  // Residue after data and FCS

    // ------------------------------------------------------------------
    // Frame result words
    // ------------------------------------------------------------------
    localparam logic [7:0]  CHAR_GOOD   = 8'h47;
    localparam logic [7:0]  CHAR_ERROR  = 8'h65;
    localparam logic [7:0]  CHAR_ABORT  = 8'h41;

    // ------------------------------------------------------------------
    // State encodings, Gray along the usual path
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TX_FLAG  = 2'h0,
        TX_DATA  = 2'h1,
        TX_FCS   = 2'h3,
        TX_CLOSE = 2'h2
    } hduf_tx_st_t;

    typedef enum logic [1:0] {
        RX_HUNT  = 2'h0,
        RX_SYNC  = 2'h1,
        RX_FRAME = 2'h3
    } hduf_rx_st_t;
endpackage
`default_nettype wire

// file: hdl/hduf_crc16.sv
`timescale 1ns/100ps
`default_nettype none
module hduf_crc16 import hduf_pkg::*; (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        init,
    input  wire logic        step_en,
    input  wire logic        din,
    output logic [15:0]      crc
);
    typedef struct packed {
        logic [15:0] crc;
    } hduf_crc_state_t;

    hduf_crc_state_t s;
    hduf_crc_state_t n;
    logic [15:0]     base;

    // Preset and step may coincide, so the step runs on the preset value
    always_comb begin
        base = init ? CRC_PRESET : s.crc;
        n.crc = base;
        if (step_en) begin
            n.crc = {1'b0, base[15:1]} ^ ((base[0] ^ din) ? CRC_POLY : 16'h0000);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s.crc <= CRC_PRESET;
        end else if (clk_en) begin
            s <= n;
        end
    end

    assign crc = s.crc;

    property p_crc_preset;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && init && !step_en) |=> (crc == CRC_PRESET);
    endproperty
    a_crc_preset: assert property (p_crc_preset) else $error("crc not preset");
endmodule
`default_nettype wire

// file: hdl/hduf_rx_run.sv
`timescale 1ns/100ps
`default_nettype none
module hduf_rx_run import hduf_pkg::*; (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        bit_vld,
    input  wire logic        din,
    output logic             is_stuff,
    output logic             is_flag,
    output logic             is_abort,
    output logic [2:0]       ones
);
    typedef struct packed {
        logic [2:0] ones;
    } hduf_run_state_t;

    hduf_run_state_t s;
    hduf_run_state_t n;

    // Classify the arriving bit against the run of ones before it
    assign is_stuff = bit_vld && !din && (s.ones == STUFF_RUN);
    assign is_flag  = bit_vld && !din && (s.ones == FLAG_RUN);
    assign is_abort = bit_vld && din && (s.ones >= FLAG_RUN);
    assign ones     = s.ones;

    // Saturates so a long idle run of ones keeps reading as abort
    always_comb begin
        n = s;
        if (bit_vld) begin
            n.ones = !din ? 3'h0 : ((s.ones == RUN_MAX) ? RUN_MAX : s.ones + 3'h1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s.ones <= 3'h0;
        end else if (clk_en) begin
            s <= n;
        end
    end

    property p_run_count;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && bit_vld && din && s.ones < RUN_MAX) |=> (s.ones == $past(s.ones) + 3'h1);
    endproperty
    a_run_count: assert property (p_run_count) else $error("ones run miscounted");
endmodule
`default_nettype wire

// file: hdl/hdlc_uart_framer.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Device packs and unpacks frames: flags, CRC, zero stuffing, line bits.
// - Ninth host bit is an escape only when escape enable set, else ignored.
// - On connection complete the device sends c, d or v to host.
// - With no host data the transmitter sends flags continuously.
// - With host data the transmitter runs the CRC and stuffs zeros.
// - Missing next byte means end of frame: CTS off, send CRC, flags.
// - After first closing flag CTS goes low again for next frame.
// - Receiver hunts flags, then runs CRC and forwards destuffed bytes.
// - Payload is 8-bit only; ninth bit is escape in, result marker out.
// - On closing flag forward last byte and two CRC bytes, then check; the code forwards each byte as soon as its eighth bit arrives, before the flag.
// - After CRC bytes send G if check matches, else e.
// - Seven or more ones abort the frame and send A.
// - Result word raises result flag on the result pin when selected.
// - In ninth-bit mode with both selects set, ninth bit marks result.
// - Result flag drops when next frame data is detected.
// - Escape on, ninth function off: ninth bit follows the interrupt pin.
module hdlc_uart_framer import hduf_pkg::*; #(
    parameter int DATA_W = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  wire logic             framing_enable,
    input  wire logic             ninth_bit_escape_enable,
    input  wire logic             nine_bit_data_select,
    input  wire logic             ninth_bit_function,
    input  wire logic             result_output_pin_result_select,
    input  wire logic             int_n,
    input  wire logic             connect_strobe,
    input  wire logic [7:0]       connect_char,
    input  wire logic             host_tx_valid,
    input  wire logic [DATA_W-1:0] host_tx_byte,
    input  wire logic             host_tx_ninth,
    output logic                  cts_n,
    output logic                  host_escape,
    input  wire logic             line_tx_req,
    output logic                  line_tx_bit,
    input  wire logic             line_rx_valid,
    input  wire logic             line_rx_bit,
    output logic                  host_rx_valid,
    output logic [DATA_W-1:0]     host_rx_byte,
    output logic                  host_rx_ninth,
    output logic                  result_output_pin
);
    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (DATA_W != 8) begin : g_bad_width
        $error("payload words are eight bits only");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        hduf_tx_st_t tx_st;
        logic [7:0]  tx_sh;
        logic [3:0]  tx_cnt;
        logic [2:0]  tx_ones;
        logic        tx_fcs_hi;
        logic [7:0]  hold;
        logic        hold_vld;
        logic        cts_n;
        logic        esc;
        logic        line_bit;
        hduf_rx_st_t rx_st;
        logic [7:0]  rx_acc;
        logic [3:0]  rx_cnt;
        logic        crc_ok;
        logic        out_vld;
        logic [7:0]  out_byte;
        logic        out_ninth;
        logic        result_flag;
        logic        result_pin;
    } hduf_state_t;

    hduf_state_t s;
    hduf_state_t n;

    logic        tx_crc_init;
    logic        tx_crc_en;
    logic        tx_bit;
    logic [15:0] tx_crc;
    logic        rx_crc_init;
    logic        rx_crc_en;
    logic [15:0] rx_crc;
    logic        rx_bit_vld;
    logic        rx_stuff;
    logic        rx_flag;
    logic        rx_abort;
    logic        rx_byte_done;
    logic        nine_on;

    // Ninth bit choice shared by result words and ordinary bytes
    function automatic logic ninth_of(input logic on, input logic fn, input logic res,
                                      input logic irq_n);
        if (!on) begin
            return 1'b0;
        end else if (fn) begin
            return res;
        end else begin
            return irq_n;
        end
    endfunction

    assign nine_on    = nine_bit_data_select && ninth_bit_escape_enable;
    assign rx_bit_vld = line_rx_valid && framing_enable;

    // ------------------------------------------------------------------
    // Frame check units and receive run detector
    // ------------------------------------------------------------------
    hduf_crc16 u_tx_crc (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .init    (tx_crc_init),
        .step_en (tx_crc_en),
        .din     (tx_bit),
        .crc     (tx_crc)
    );

    hduf_crc16 u_rx_crc (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .init    (rx_crc_init),
        .step_en (rx_crc_en),
        .din     (line_rx_bit),
        .crc     (rx_crc)
    );

    hduf_rx_run u_rx_run (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .bit_vld  (rx_bit_vld),
        .din      (line_rx_bit),
        .is_stuff (rx_stuff),
        .is_flag  (rx_flag),
        .is_abort (rx_abort),
        .ones     ()
    );

    // ------------------------------------------------------------------
    // Next state: transmit side, host input, receive side
    // ------------------------------------------------------------------
    always_comb begin
        n           = s;
        tx_crc_init = 1'b0;
        tx_crc_en   = 1'b0;
        tx_bit      = 1'b0;
        rx_crc_init = 1'b0;
        rx_crc_en   = 1'b0;
        rx_byte_done = 1'b0;
        n.esc       = 1'b0;
        n.out_vld   = 1'b0;

        // Transmit one line bit per pump request
        if (line_tx_req) begin
            if ((s.tx_st == TX_DATA || s.tx_st == TX_FCS) && s.tx_ones == STUFF_RUN) begin
                n.line_bit = 1'b0;
                n.tx_ones  = 3'h0;
            end else begin
                if (s.tx_cnt == BYTE_BITS) begin
                    n.tx_cnt = 4'h0;
                    // The first closing flag is out: ready for the next frame
                    if (s.tx_st == TX_CLOSE) begin
                        n.tx_st = TX_FLAG;
                    end
                    case (n.tx_st)
                        TX_FLAG: begin
                            if (s.hold_vld && framing_enable) begin
                                n.tx_sh     = s.hold;
                                n.hold_vld  = 1'b0;
                                n.tx_st     = TX_DATA;
                                tx_crc_init = 1'b1;
                            end else begin
                                n.tx_sh = FLAG_OCTET;
                            end
                        end
                        TX_DATA: begin
                            if (s.hold_vld) begin
                                n.tx_sh    = s.hold;
                                n.hold_vld = 1'b0;
                            end else begin
                                n.tx_sh     = ~tx_crc[7:0];
                                n.tx_fcs_hi = 1'b0;
                                n.tx_st     = TX_FCS;
                            end
                        end
                        TX_FCS: begin
                            if (!s.tx_fcs_hi) begin
                                n.tx_sh     = ~tx_crc[15:8];
                                n.tx_fcs_hi = 1'b1;
                            end else begin
                                n.tx_sh = FLAG_OCTET;
                                n.tx_st = TX_CLOSE;
                            end
                        end
                        default: begin
                            n.tx_sh = FLAG_OCTET;
                            n.tx_st = TX_FLAG;
                        end
                    endcase
                end
                tx_bit     = n.tx_sh[0];
                n.line_bit = tx_bit;
                n.tx_sh    = {1'b0, n.tx_sh[7:1]};
                n.tx_cnt   = n.tx_cnt + 4'h1;
                tx_crc_en  = (n.tx_st == TX_DATA);
                // Flags are never stuffed, so their ones do not count
                if ((n.tx_st == TX_DATA || n.tx_st == TX_FCS) && tx_bit) begin
                    n.tx_ones = s.tx_ones + 3'h1;
                end else begin
                    n.tx_ones = 3'h0;
                end
            end
        end

        // Host bytes: escapes bypass the frame, payload waits in one holder
        if (host_tx_valid) begin
            if (nine_on && host_tx_ninth) begin
                n.esc = 1'b1;
            end else if (!s.cts_n && !n.hold_vld) begin
                n.hold     = host_tx_byte;
                n.hold_vld = 1'b1;
            end
        end
        if (!framing_enable) begin
            n.tx_st    = TX_FLAG;
            n.hold_vld = 1'b0;
        end
        // Ready only with an empty holder and no trailer in flight
        n.cts_n = !framing_enable || n.hold_vld || n.tx_st == TX_FCS
                  || n.tx_st == TX_CLOSE;

        // Residue is judged at the last octet edge, before the flag's own bits step the check
        if (s.rx_cnt == 4'h0) begin
            n.crc_ok = (rx_crc == CRC_GOOD);
        end

        // Receive: flag and abort take precedence over data bits
        if (rx_bit_vld) begin
            if (rx_flag) begin
                if (s.rx_st == RX_FRAME) begin
                    n.out_vld     = 1'b1;
                    n.out_byte    = s.crc_ok ? CHAR_GOOD : CHAR_ERROR;
                    n.result_flag = 1'b1;
                end
                n.rx_st     = RX_SYNC;
                n.rx_cnt    = 4'h0;
                rx_crc_init = 1'b1;
            end else if (rx_abort) begin
                if (s.rx_st == RX_FRAME) begin
                    n.out_vld     = 1'b1;
                    n.out_byte    = CHAR_ABORT;
                    n.result_flag = 1'b1;
                end
                n.rx_st  = RX_HUNT;
                n.rx_cnt = 4'h0;
            end else if (!rx_stuff && s.rx_st != RX_HUNT) begin
                n.rx_acc  = {line_rx_bit, s.rx_acc[7:1]};
                n.rx_cnt  = s.rx_cnt + 4'h1;
                rx_crc_en = 1'b1;
                if (n.rx_cnt == BYTE_BITS) begin
                    rx_byte_done = 1'b1;
                    n.rx_cnt     = 4'h0;
                    n.out_vld    = 1'b1;
                    n.out_byte   = n.rx_acc;
                    n.rx_st      = RX_FRAME;
                    if (s.rx_st == RX_SYNC) begin
                        n.result_flag = 1'b0;
                    end
                end
            end
        end
        if (!framing_enable) begin
            n.rx_st = RX_HUNT;
        end
        n.out_ninth = ninth_of(nine_on, ninth_bit_function, n.result_flag, int_n);

        // Connect announcement wins the host line in its cycle
        if (connect_strobe) begin
            n.out_vld   = 1'b1;
            n.out_byte  = connect_char;
            n.out_ninth = ninth_of(nine_on, ninth_bit_function, 1'b0, int_n);
        end
        n.result_pin = result_output_pin_result_select && n.result_flag;
    end

    // ------------------------------------------------------------------
    // State register, frozen while the clock enable is low
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s           <= '0;
            s.tx_st     <= TX_FLAG;
            s.tx_cnt    <= TX_CNT_RST;
            s.cts_n     <= 1'b1;
            s.line_bit  <= 1'b1;
            s.rx_st     <= RX_HUNT;
        end else if (clk_en) begin
            s <= n;
        end
    end

    // Every output is a field of the state register
    assign cts_n             = s.cts_n;
    assign host_escape       = s.esc;
    assign line_tx_bit       = s.line_bit;
    assign host_rx_valid     = s.out_vld;
    assign host_rx_byte      = s.out_byte;
    assign host_rx_ninth     = s.out_ninth;
    assign result_output_pin = s.result_pin;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_idle_flag;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && line_tx_req && s.tx_st == TX_FLAG && s.tx_cnt < BYTE_BITS)
            |=> (line_tx_bit == FLAG_OCTET[$past(s.tx_cnt[2:0])]);
    endproperty
    a_idle_flag: assert property (p_idle_flag) else $error("idle bit not flag");

    property p_stuff;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && line_tx_req && s.tx_st == TX_DATA && s.tx_ones == STUFF_RUN)
            |=> (!line_tx_bit && s.tx_ones == 3'h0);
    endproperty
    a_stuff: assert property (p_stuff) else $error("zero not inserted");

    property p_eof;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && framing_enable && line_tx_req && s.tx_st == TX_DATA
            && s.tx_cnt == BYTE_BITS && !s.hold_vld && s.tx_ones != STUFF_RUN)
            |=> (cts_n && s.tx_st == TX_FCS && line_tx_bit == ~$past(tx_crc[0]));
    endproperty
    a_eof: assert property (p_eof) else $error("end of frame mishandled");

    property p_ready_again;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && framing_enable && line_tx_req && s.tx_st == TX_CLOSE
            && s.tx_cnt == BYTE_BITS) |=> (!cts_n && s.tx_st == TX_FLAG);
    endproperty
    a_ready_again: assert property (p_ready_again) else $error("cts not ready");

    property p_good;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && rx_bit_vld && rx_flag && s.rx_st == RX_FRAME && !connect_strobe)
            |=> (host_rx_valid && host_rx_byte == ($past(s.crc_ok) ? CHAR_GOOD : CHAR_ERROR));
    endproperty
    a_good: assert property (p_good) else $error("wrong result word");

    property p_abort;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && rx_bit_vld && rx_abort && s.rx_st == RX_FRAME && !connect_strobe)
            |=> (host_rx_valid && host_rx_byte == CHAR_ABORT && s.rx_st == RX_HUNT);
    endproperty
    a_abort: assert property (p_abort) else $error("abort not reported");

    property p_result_pin;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && rx_bit_vld && rx_flag && s.rx_st == RX_FRAME)
            |=> (result_output_pin == $past(result_output_pin_result_select));
    endproperty
    a_result_pin: assert property (p_result_pin) else $error("result pin wrong");

    property p_ninth;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && rx_bit_vld && rx_flag && s.rx_st == RX_FRAME && !connect_strobe
            && nine_on && ninth_bit_function) |=> host_rx_ninth;
    endproperty
    a_ninth: assert property (p_ninth) else $error("ninth bit not raised");

    property p_drop;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && rx_byte_done && s.rx_st == RX_SYNC) |=> (!s.result_flag && !result_output_pin);
    endproperty
    a_drop: assert property (p_drop) else $error("result flag held");

    property p_escape;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && host_tx_valid && host_tx_ninth && nine_on)
            |=> (host_escape && s.hold == $past(s.hold));
    endproperty
    a_escape: assert property (p_escape) else $error("escape framed");

    c_good_frame: cover property (@(posedge sys_clk) disable iff (!rst_n)
        host_rx_valid && host_rx_byte == CHAR_GOOD && s.result_flag);
    c_abort: cover property (@(posedge sys_clk) disable iff (!rst_n)
        host_rx_valid && host_rx_byte == CHAR_ABORT);
    c_tx_frame_end: cover property (@(posedge sys_clk) disable iff (!rst_n)
        s.tx_st == TX_CLOSE ##1 s.tx_st == TX_FLAG);
endmodule
`default_nettype wire

// file: dv/hduf_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------
// Host controller behind the UART
// ------------------------------------
module hduf_host_model (
    input  wire logic       sys_clk,
    input  wire logic       cts_n,
    input  wire logic       send,
    input  wire logic [7:0] byte_in,
    output logic            tx_valid,
    output logic [7:0]      tx_byte
);
    initial tx_valid = '0;
    initial tx_byte = '0;
    // One byte per ready level; the extra ready at frame end goes unused
    always @(posedge sys_clk) begin
        tx_valid <= send && !cts_n && !tx_valid;
        tx_byte  <= tx_valid ? ~tx_byte : byte_in; // Stale data scrambled
    end
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------
// Loopback bench
// ------------------------------------
module testbench import hduf_pkg::*; ;
    logic        sys_clk = '0, rst_n = '0, fn9 = '1, int_n = '1, cstb = '0;
    logic        send = '0, ninth = '0, loop_on = '0, phase = '0, req = '0;
    logic        fen = '0, gsel = '1, primed = '0;
    logic        rxv = '0, rxb = '0, htv, cts_n, esc, tbit, rv, r9, pin;
    logic [7:0]  cch = '0, hb, sbyte = '0, rbyte;
    logic [7:0]  cv[3] = '{8'h63, 8'h64, 8'h76};
    logic [15:0] f;
    logic [9:0]  rxq[$];
    int          n_mismatch = 0, cmp_count = 0, cyc = 0, n_esc = 0;

    always #2 sys_clk = ~sys_clk;

    hdlc_uart_framer hdlc_uart_framer_inst (.sys_clk, .rst_n, .clk_en(1'h1),
        .framing_enable(fen), .ninth_bit_escape_enable(1'h1),
        .nine_bit_data_select(1'h1), .ninth_bit_function(fn9),
        .result_output_pin_result_select(gsel), .int_n, .connect_strobe(cstb),
        .connect_char(cch), .host_tx_valid(htv), .host_tx_byte(hb),
        .host_tx_ninth(ninth), .cts_n, .host_escape(esc), .line_tx_req(req),
        .line_tx_bit(tbit), .line_rx_valid(rxv), .line_rx_bit(rxb),
        .host_rx_valid(rv), .host_rx_byte(rbyte), .host_rx_ninth(r9),
        .result_output_pin(pin));
    hduf_host_model hduf_host_model_inst (.sys_clk, .cts_n, .send,
        .byte_in(sbyte), .tx_valid(htv), .tx_byte(hb));

    // Half-rate pump: a bit asked for is handed back to the receiver next time
    always @(posedge sys_clk) begin
        cyc   <= cyc + 1;
        phase <= loop_on && !phase;
        // Nothing is looped back until a requested bit stands, else idle ones leak in
        if (loop_on) begin
            primed <= primed || req;
            req    <= !phase;
            rxv    <= !phase && primed;
            rxb    <= tbit;
        end
        if (rv === 1'h1) rxq.push_back({r9, pin, rbyte});
        if (esc === 1'h1) n_esc <= n_esc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Waits a bounded time for the next host word; an empty queue never matches
    task automatic pop(input logic [9:0] exp);
        for (int i = 0; i < 2000 && rxq.size() == 0; i++) @(posedge sys_clk);
        check(rxq.size() > 0 ? {6'h00, rxq.pop_front()} : 16'hFFFF, {6'h00, exp});
    endtask

    // Line bits LSB first, lowest octet first
    task automatic rx_seq(input logic [23:0] s);
        for (int i = 0; i < 24; i++) begin
            rxv <= 1'h1;
            rxb <= s[i];
            @(posedge sys_clk);
        end
        rxv <= 1'h0;
        @(posedge sys_clk);
    endtask

    task automatic host_send(input logic [7:0] b, input logic nb);
        sbyte <= b;
        ninth <= nb;
        send  <= 1'h1;
        for (int i = 0; i < 400; i++) begin
            @(posedge sys_clk);
            if (htv === 1'h1) break;
        end
        send <= 1'h0;
        #1;
        check({15'h0000, cts_n}, {15'h0000, !nb});
    endtask

    // Reflected check over one byte, sent complemented
    function automatic logic [15:0] fcs(input logic [7:0] d);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 16'h8408 : 16'h0000);
        return ~c;
    endfunction

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Framing held off keeps the host waiting; connect words then reach it
    task automatic t_connect;
        check({15'h0000, cts_n}, 16'h0001);
        fen <= 1'h1;
        repeat (4) @(posedge sys_clk);
        check({15'h0000, cts_n}, 16'h0000);
        foreach (cv[i]) begin
            cch  <= cv[i];
            cstb <= 1'h1;
            @(posedge sys_clk);
            cstb <= 1'h0;
            pop({2'h0, cv[i]});
        end
    endtask

    // Abort after one byte; ninth bit copies the idle interrupt line, pin not selected
    task automatic t_rx_abort;
        fn9  <= 1'h0;
        gsel <= 1'h0;
        rx_seq({8'hFF, 8'h5A, 8'h7E});
        pop(10'h25A);
        pop({2'h2, CHAR_ABORT});
        gsel <= 1'h1;
    endtask

    // Bad check word: ninth bit marks the result although the interrupt line is low
    task automatic t_rx_error;
        fn9   <= 1'h1;
        int_n <= 1'h0;
        rx_seq({8'h7E, 8'h33, 8'h7E});
        pop(10'h033);
        pop({2'h3, CHAR_ERROR});
    endtask

    // Escape byte in loopback is never framed; idle flags give the host nothing
    task automatic t_escape;
        loop_on <= 1'h1;
        host_send(8'hA5, 1'h1);
        repeat (200) @(posedge sys_clk);
        check(16'(n_esc), 16'h0001);
        check(16'(rxq.size()), 16'h0000);
    endtask

    // One-byte frame looped back: data, both check bytes, good result, ready again
    task automatic t_frame;
        host_send(8'hFF, 1'h0);
        f = fcs(8'hFF);
        pop(10'h0FF);
        pop({2'h0, f[7:0]});
        pop({2'h0, f[15:8]});
        pop({2'h3, CHAR_GOOD});
        check({15'h0000, cts_n}, 16'h0000);
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge sys_clk);
        t_connect();
        t_rx_abort();
        t_rx_error();
        t_escape();
        t_frame();
        end_sim();
    end
endmodule
`default_nettype wire
